// *** hw/wkpm_pkg.sv ***
// wkpm_pkg: register map, field positions, reset values and carriers
// for the wake-event and port-2 pin-mux block.
// assumes a 32-bit wishbone slave with word-indexed registers.
package wkpm_pkg;

    // ----------------------------------------
    // bus shape
    // ----------------------------------------
    localparam int unsigned WB_AW = 12;
    localparam int unsigned IDX_W = 10;

    // ----------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [7:0] IDX_ADDR_QUAL = 8'h24;
    localparam logic [7:0] IDX_KBC_SEL = 8'hC0;
    localparam logic [7:0] IDX_GLOBAL_EN = 8'hC5;
    localparam logic [7:0] IDX_WAKE_STATUS = 8'hC7;
    localparam logic [7:0] IDX_WAKE_ENABLE = 8'hC8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hC9;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned BIT_GLOBAL_EN = 0;
    localparam int unsigned BIT_ADDR_QUAL = 6;
    localparam int unsigned BIT_KBC_SEL = 3;
    localparam int unsigned BIT_PORT2_RING = 1;
    localparam int unsigned BIT_PORT1_RING = 2;
    localparam int unsigned BIT_KEYBOARD = 3;
    localparam int unsigned BIT_MOUSE = 4;
    localparam logic [7:0] WAKE_BITS = 8'h1E;
    localparam logic [7:0] CLEAR_BITS = 8'h1F;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] RST_WAKE_STATUS = 8'h00;
    localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic RST_GLOBAL_EN = 1'b0;
    localparam logic RST_ADDR_QUAL = 1'b0;
    localparam logic RST_KBC_SEL = 1'b0;
    localparam logic RST_PIN = 1'b1;

    // ----------------------------------------
    // levels seen by a function whose pin is taken
    // ----------------------------------------
    localparam logic UNCONN_MODEM = 1'b1;
    localparam logic UNCONN_ADDR = 1'b0;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic mouse;
        logic keyboard;
        logic port1Ring;
        logic port2Ring;
    } wkpm_wake_s;

    typedef struct packed {
        logic rts;
        logic cts;
        logic dtr;
        logic dsr;
        logic dcd;
        logic ri;
    } wkpm_pins_s;

endpackage : wkpm_pkg

// *** hw/wkpm_sync.sv ***
// wkpm_sync: two-flop synchroniser for a vector of unrelated levels.
// assumes each bit is an independent level; no word coherence given.
`timescale 1ns/1ps
module wkpm_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;

endmodule : wkpm_sync

// *** hw/wkpm_top.sv ***
// wkpm_top: wake-event status/enable registers, power-event output,
// interrupt, and port-2 modem pin multiplexing, behind wishbone.
// assumes reset is the standby-supply power-on reset and mainReset
// carries main-supply, soft and hard resets, both on core_clk.
`timescale 1ns/1ps

module wkpm_top
    import wkpm_pkg::*;
(
    // clock and resets
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mainReset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // wake sources, asynchronous levels
    input wire wkpm_wake_s wakeIn,
    // system outputs
    output logic powerEventOutN,
    output logic irqOut,
    // modem pads of port 2
    input wire wkpm_pins_s padIn,
    output wkpm_pins_s padOut,
    output wkpm_pins_s padOe,
    // serial port side
    input wire logic port2RequestToSendN,
    input wire logic port2TerminalReadyN,
    output logic port2ClearToSendN,
    output logic port2SetReadyN,
    output logic port2CarrierDetectN,
    output logic port2RingIndicateN,
    // keyboard controller side
    input wire logic kbcAuxOutputA,
    input wire logic kbcAuxOutputB,
    // upper host address, bits 15:12
    output logic [3:0] hostAddrHi
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic regHit(input logic [IDX_W-1:0] idx, input logic [7:0] target);
        regHit = (idx == {2'b00, target});
    endfunction : regHit

    function automatic logic [7:0] wakeToReg(input wkpm_wake_s w);
        logic [7:0] r;
        r = 8'h00;
        r[BIT_PORT2_RING] = w.port2Ring;
        r[BIT_PORT1_RING] = w.port1Ring;
        r[BIT_KEYBOARD] = w.keyboard;
        r[BIT_MOUSE] = w.mouse;
        wakeToReg = r;
    endfunction : wakeToReg

    // level a function sees: the synced pad when selected, else its idle level
    function automatic logic pinPick(input logic sel, input logic pad, input logic idle);
        pinPick = sel ? pad : idle;
    endfunction : pinPick

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    wkpm_wake_s wakeSync;
    wkpm_pins_s padSync;

    wkpm_sync #(
        .W(4),
        .INIT(4'h0)
    ) u_wakeSync (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(wakeIn),
        .syncOut(wakeSync)
    );

    wkpm_sync #(
        .W(6),
        .INIT(6'h3F)
    ) u_padSync (
        .core_clk(core_clk),
        .reset(reset),
        .asyncIn(padIn),
        .syncOut(padSync)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic [IDX_W-1:0] busIdx;
    logic busReq;
    logic wrStrobe;
    logic [7:0] wrByte;

    assign busIdx = wb_adr_i[WB_AW-1:2];
    assign busReq = wb_cyc_i & wb_stb_i;
    // a write with byte lane 0 enabled lands on the edge where ack is high, exactly once
    assign wrStrobe = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign wrByte = wb_dat_i[7:0];

    // one decode per register, shared by every write path
    logic wrStatus;
    logic wrEnable;
    logic wrMask;
    logic wrGlobal;
    logic wrQual;
    logic wrKbc;

    assign wrStatus = wrStrobe & regHit(busIdx, IDX_WAKE_STATUS);
    assign wrEnable = wrStrobe & regHit(busIdx, IDX_WAKE_ENABLE);
    assign wrMask = wrStrobe & regHit(busIdx, IDX_IRQ_MASK);
    assign wrGlobal = wrStrobe & regHit(busIdx, IDX_GLOBAL_EN);
    assign wrQual = wrStrobe & regHit(busIdx, IDX_ADDR_QUAL);
    assign wrKbc = wrStrobe & regHit(busIdx, IDX_KBC_SEL);

    // ----------------------------------------
    // standby-domain registers: wake status, enable, global enable, mask
    // ----------------------------------------
    logic [7:0] wakeStatus_q;
    logic [7:0] wakeStatus_d;
    logic [7:0] wakeEnable_q;
    logic [7:0] wakeEnable_d;
    logic [7:0] irqMask_q;
    logic [7:0] irqMask_d;
    logic globalEn_q;
    logic globalEn_d;
    logic [7:0] wakeEvents;
    logic [7:0] clearBits;

    always_comb begin
        wakeEvents = wakeToReg(wakeSync);
        clearBits = 8'h00;
        if (wrStatus) begin
            clearBits = wrByte & CLEAR_BITS;
        end
        // set beats clear so no event is lost on a clearing write
        wakeStatus_d = (wakeStatus_q & ~clearBits) | wakeEvents;
        wakeEnable_d = wakeEnable_q;
        if (wrEnable) begin
            wakeEnable_d = wrByte & WAKE_BITS;
        end
        irqMask_d = irqMask_q;
        if (wrMask) begin
            irqMask_d = wrByte & WAKE_BITS;
        end
        globalEn_d = globalEn_q;
        if (wrGlobal) begin
            globalEn_d = wrByte[BIT_GLOBAL_EN];
        end
    end

    // mainReset deliberately absent: these live on the standby supply
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wakeStatus_q <= RST_WAKE_STATUS;
            wakeEnable_q <= RST_WAKE_ENABLE;
            irqMask_q <= RST_IRQ_MASK;
            globalEn_q <= RST_GLOBAL_EN;
        end else begin
            wakeStatus_q <= wakeStatus_d;
            wakeEnable_q <= wakeEnable_d;
            irqMask_q <= irqMask_d;
            globalEn_q <= globalEn_d;
        end
    end

    // ----------------------------------------
    // power event and interrupt outputs
    // ----------------------------------------
    logic pmeN_q;
    logic pmeN_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] pending;

    always_comb begin
        // live events count too, so assertion is not a cycle late
        pending = (wakeStatus_q | wakeEvents) & wakeEnable_q;
        pmeN_d = ~(globalEn_q & (|pending));
        irq_d = |(wakeStatus_d & irqMask_q);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pmeN_q <= RST_PIN;
            irq_q <= 1'b0;
        end else begin
            pmeN_q <= pmeN_d;
            irq_q <= irq_d;
        end
    end

    assign powerEventOutN = pmeN_q;
    assign irqOut = irq_q;

    // ----------------------------------------
    // main-domain configuration: pin-mux selects
    // ----------------------------------------
    logic addrQual_q;
    logic addrQual_d;
    logic kbcSel_q;
    logic kbcSel_d;

    always_comb begin
        addrQual_d = addrQual_q;
        kbcSel_d = kbcSel_q;
        if (wrQual) begin
            addrQual_d = wrByte[BIT_ADDR_QUAL];
        end
        if (wrKbc) begin
            kbcSel_d = wrByte[BIT_KBC_SEL];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || mainReset) begin
            addrQual_q <= RST_ADDR_QUAL;
            kbcSel_q <= RST_KBC_SEL;
        end else begin
            addrQual_q <= addrQual_d;
            kbcSel_q <= kbcSel_d;
        end
    end

    // ----------------------------------------
    // pin multiplexing
    // ----------------------------------------
    wkpm_pins_s padOut_q;
    wkpm_pins_s padOut_d;
    wkpm_pins_s padOe_q;
    wkpm_pins_s padOe_d;
    logic [3:0] hostAddr_q;
    logic [3:0] hostAddr_d;
    logic [3:0] modemIn_q;
    logic [3:0] modemIn_d;

    always_comb begin
        padOut_d = '1;
        padOe_d = '0;
        padOut_d.rts = port2RequestToSendN;
        padOe_d.rts = ~addrQual_q;
        padOut_d.dtr = port2TerminalReadyN;
        padOe_d.dtr = ~addrQual_q;
        padOut_d.dcd = kbcAuxOutputA;
        padOe_d.dcd = kbcSel_q;
        padOut_d.ri = kbcAuxOutputB;
        padOe_d.ri = kbcSel_q;
        hostAddr_d[0] = pinPick(addrQual_q, padSync.rts, UNCONN_ADDR);
        hostAddr_d[1] = pinPick(addrQual_q, padSync.cts, UNCONN_ADDR);
        hostAddr_d[2] = pinPick(addrQual_q, padSync.dtr, UNCONN_ADDR);
        hostAddr_d[3] = pinPick(addrQual_q, padSync.dsr, UNCONN_ADDR);
        modemIn_d[0] = pinPick(!addrQual_q, padSync.cts, UNCONN_MODEM);
        modemIn_d[1] = pinPick(!addrQual_q, padSync.dsr, UNCONN_MODEM);
        modemIn_d[2] = pinPick(!kbcSel_q, padSync.dcd, UNCONN_MODEM);
        modemIn_d[3] = pinPick(!kbcSel_q, padSync.ri, UNCONN_MODEM);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            padOut_q <= '1;
            padOe_q <= '0;
            hostAddr_q <= {4{UNCONN_ADDR}};
            modemIn_q <= {4{UNCONN_MODEM}};
        end else begin
            padOut_q <= padOut_d;
            padOe_q <= padOe_d;
            hostAddr_q <= hostAddr_d;
            modemIn_q <= modemIn_d;
        end
    end

    assign padOut = padOut_q;
    assign padOe = padOe_q;
    assign hostAddrHi = hostAddr_q;
    assign port2ClearToSendN = modemIn_q[0];
    assign port2SetReadyN = modemIn_q[1];
    assign port2CarrierDetectN = modemIn_q[2];
    assign port2RingIndicateN = modemIn_q[3];

    // ----------------------------------------
    // wishbone answer and read data
    // ----------------------------------------
    logic ack_q;
    logic ack_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic [7:0] rdByte;

    always_comb begin
        rdByte = 8'h00;
        if (regHit(busIdx, IDX_WAKE_STATUS)) begin
            rdByte = wakeStatus_q;
        end else if (regHit(busIdx, IDX_WAKE_ENABLE)) begin
            rdByte = wakeEnable_q;
        end else if (regHit(busIdx, IDX_IRQ_MASK)) begin
            rdByte = irqMask_q;
        end else if (regHit(busIdx, IDX_GLOBAL_EN)) begin
            rdByte[BIT_GLOBAL_EN] = globalEn_q;
        end else if (regHit(busIdx, IDX_ADDR_QUAL)) begin
            rdByte[BIT_ADDR_QUAL] = addrQual_q;
        end else if (regHit(busIdx, IDX_KBC_SEL)) begin
            rdByte[BIT_KBC_SEL] = kbcSel_q;
        end
        // one wait state; ack drops the cycle after it is given
        ack_d = busReq & ~ack_q;
        rdData_d = rdData_q;
        if (ack_d && !wb_we_i) begin
            rdData_d = {24'h000000, rdByte};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdData_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdData_q <= rdData_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

endmodule : wkpm_top

// *** sim/wkpm_pad_model.sv ***
// wkpm_pad_model: far-side drivers on the port-2 modem pads
// assumes the far side drives every pad that the block leaves free
`timescale 1ns/1ps
module wkpm_pad_model
    import wkpm_pkg::*;
(
    // block side
    input wire wkpm_pins_s padOut,
    input wire wkpm_pins_s padOe,
    // far side
    input wire wkpm_pins_s extPad,
    output wkpm_pins_s padIn
);
    // a driven pad shows the block's value, a free pad the far side's
    assign padIn = (padOut & padOe) | (extPad & ~padOe);
endmodule : wkpm_pad_model

// *** sim/wkpm_top_asserts.sv ***
// wkpm_top_asserts: port-level checks of the wake and pin-mux block
// assumes one clock, core_clk, and synchronous reset
`timescale 1ns/1ps
module wkpm_top_asserts
    import wkpm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // outputs and sources
    input wire logic powerEventOutN,
    input wire wkpm_pins_s padOut,
    input wire wkpm_pins_s padOe,
    input wire logic port2RequestToSendN,
    input wire logic port2TerminalReadyN,
    input wire logic port2ClearToSendN,
    input wire logic port2SetReadyN,
    input wire logic port2CarrierDetectN,
    input wire logic port2RingIndicateN,
    input wire logic kbcAuxOutputA,
    input wire logic kbcAuxOutputB,
    input wire logic [3:0] hostAddrHi
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wbTake;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_timing_a: assert property (wbTake |=> ackPulse) else $error("ack late or long");
    // a write may have just released the event, so one cycle of grace
    pev_sticky_a: assert property (!powerEventOutN && !$past(wb_ack_o && wb_we_i) |=> !powerEventOutN)
        else $error("power event dropped without write");
    rts_route_a: assert property (padOe.rts |-> padOut.rts == $past(port2RequestToSendN))
        else $error("rts pad not following port");
    dtr_route_a: assert property (padOe.dtr |-> padOut.dtr == $past(port2TerminalReadyN))
        else $error("dtr pad not following port");
    addr_idle_a: assert property (padOe.rts |-> hostAddrHi == 4'h0 && padOe.dtr)
        else $error("address inputs not idle");
    modem_idle_a: assert property (!padOe.rts |-> port2ClearToSendN && port2SetReadyN && !padOe.cts)
        else $error("modem inputs not idle");
    dcd_route_a: assert property (padOe.dcd |-> padOut.dcd == $past(kbcAuxOutputA) && port2CarrierDetectN)
        else $error("carrier pad wrong");
    ri_route_a: assert property (padOe.ri |-> padOut.ri == $past(kbcAuxOutputB) && port2RingIndicateN)
        else $error("ring pad wrong");
endmodule : wkpm_top_asserts

bind wkpm_top wkpm_top_asserts u_chk (.core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .powerEventOutN, .padOut, .padOe, .port2RequestToSendN, .port2TerminalReadyN, .port2ClearToSendN,
    .port2SetReadyN, .port2CarrierDetectN, .port2RingIndicateN, .kbcAuxOutputA, .kbcAuxOutputB, .hostAddrHi);

// *** sim/tb_top.sv ***
// tb_top: self-checking bench of the wake and pin-mux block
// assumes the pad model closes the modem pads; one clock domain
`timescale 1ns/1ps
module tb_top;
    import wkpm_pkg::*;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic mainReset = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [11:0] wbAdr = 12'h000;
    logic [3:0] wbSel = 4'hF;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic wbAck, pevN, irq, ctsN, dsrN, dcdN, riN;
    logic rtsN = 1'b1, dtrN = 1'b1, kbcA = 1'b0, kbcB = 1'b1;
    logic [3:0] addrHi;
    wkpm_wake_s wake = '0;
    wkpm_pins_s extPad = '1, padIn, padOut, padOe;
    int nFail = 0, checksDone = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    wkpm_pad_model PAD (.padOut(padOut), .padOe(padOe), .extPad(extPad), .padIn(padIn));
    wkpm_top DUT (.core_clk(core_clk), .reset(reset), .mainReset(mainReset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wakeIn(wake), .powerEventOutN(pevN), .irqOut(irq),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .port2RequestToSendN(rtsN),
        .port2TerminalReadyN(dtrN), .port2ClearToSendN(ctsN), .port2SetReadyN(dsrN),
        .port2CarrierDetectN(dcdN), .port2RingIndicateN(riN), .kbcAuxOutputA(kbcA),
        .kbcAuxOutputB(kbcB), .hostAddrHi(addrHi));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results;
        if (nFail == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ad
    // no fixed wait: the global timeout bounds a missing ack
    task automatic wbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatI <= d;
        @(posedge core_clk);
        while (wbAck !== 1'b1) @(posedge core_clk);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge core_clk);
    endtask : wbXfer
    task automatic wbWr(input logic [11:0] a, input logic [31:0] d);
        wbXfer(a, 1'b1, d);
    endtask : wbWr
    task automatic wbRd(input logic [11:0] a, input logic [31:0] exp);
        wbXfer(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask : wbRd
    task automatic mainPulse;
        mainReset <= 1'b1;
        tick(1);
        mainReset <= 1'b0;
    endtask : mainPulse
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic tRegReset;
        wbRd(ad(IDX_WAKE_STATUS), 32'h0);
        wbRd(ad(IDX_WAKE_ENABLE), 32'h0);
        wbRd(ad(IDX_GLOBAL_EN), 32'h0);
        // low byte lane off: the write is acked but must not land
        wbSel <= 4'hE;
        wbWr(ad(IDX_GLOBAL_EN), 32'h1);
        wbSel <= 4'hF;
        wbRd(ad(IDX_GLOBAL_EN), 32'h0);
        wbRd(12'h3FC, 32'h0);
        check(32'(pevN), 32'h1);
    endtask : tRegReset
    task automatic tWake;
        logic [31:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 32'h2 << i;
            wake <= wkpm_wake_s'(4'h1 << i);
            tick(4);
            // clearing while the source is still high: the set wins
            wbWr(ad(IDX_WAKE_STATUS), b);
            wbRd(ad(IDX_WAKE_STATUS), b);
            wake <= '0;
            tick(4);
            wbRd(ad(IDX_WAKE_STATUS), b);
            check(32'(pevN), 32'h1);
            wbWr(ad(IDX_WAKE_ENABLE), b);
            wbWr(ad(IDX_GLOBAL_EN), 32'h1);
            wbWr(ad(IDX_IRQ_MASK), b);
            tick(1);
            check(32'(pevN), 32'h0);
            check(32'(irq), 32'h1);
            mainPulse();
            wbRd(ad(IDX_WAKE_ENABLE), b);
            wbWr(ad(IDX_WAKE_STATUS), {24'h0, CLEAR_BITS} & ~b);
            wbRd(ad(IDX_WAKE_STATUS), b);
            check(32'(pevN), 32'h0);
            wbWr(ad(IDX_GLOBAL_EN), 32'h0);
            tick(1);
            check(32'(pevN), 32'h1);
            wbWr(ad(IDX_GLOBAL_EN), 32'h1);
            wbWr(ad(IDX_WAKE_STATUS), b);
            tick(1);
            check(32'(pevN), 32'h1);
            check(32'(irq), 32'h0);
            wbRd(ad(IDX_WAKE_STATUS), 32'h0);
            wbWr(ad(IDX_WAKE_ENABLE), 32'h0);
        end
    endtask : tWake
    task automatic tMux;
        rtsN <= 1'b0;
        extPad <= '{rts:1'b1, cts:1'b0, dtr:1'b1, dsr:1'b1, dcd:1'b0, ri:1'b1};
        tick(5);
        check(32'(padOe), 32'h28);
        check({30'h0, padOut.rts, padOut.dtr}, 32'h1);
        check({28'h0, ctsN, dsrN, dcdN, riN}, 32'h5);
        check(32'(addrHi), 32'h0);
        wbWr(ad(IDX_ADDR_QUAL), 32'h40);
        extPad <= '{rts:1'b1, cts:1'b0, dtr:1'b0, dsr:1'b1, dcd:1'b0, ri:1'b1};
        tick(5);
        check(32'(addrHi), 32'h9);
        check(32'(padOe), 32'h0);
        check({28'h0, ctsN, dsrN, dcdN, riN}, 32'hD);
        wbRd(ad(IDX_ADDR_QUAL), 32'h40);
        wbWr(ad(IDX_KBC_SEL), 32'h08);
        kbcA <= 1'b1;
        kbcB <= 1'b0;
        tick(5);
        check(32'(padOe), 32'h03);
        check({30'h0, padOut.dcd, padOut.ri}, 32'h2);
        check({30'h0, dcdN, riN}, 32'h3);
        mainPulse();
        tick(2);
        check(32'(padOe), 32'h28);
        wbRd(ad(IDX_KBC_SEL), 32'h0);
    endtask : tMux
    // ----------------------------------------
    // main sequence and timeout
    // ----------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            nFail++;
            results();
        end
    end
    initial begin
        tick(10);
        reset <= 1'b0;
        tick(3);
        tRegReset();
        tWake();
        tMux();
        results();
    end
endmodule : tb_top
